// ===== hw/tfoc_top.sv
// Contract
// - Direct mode: output follows its sensor ON/OFF state.
// - Host mode: output follows the host-written level.
// - Toggle mode: output inverts on each new touch or proximity event.
// - PWM mode: output pulses at configured duty while sensor is ON.
// - Buzzer pin carries PWM at configured period for configured length.
// - Touch starts buzzer burst that ends by itself after its length.
// - Any new touch event raises the host alert.
// - Corrupt configuration update falls back to last valid configuration.
// - Active mode issues periodic scan strobes at refresh interval.
// - Deep sleep issues no scans until host resume command or proximity wake.
// - Proximity event with wake enabled returns sleep to Active.
// - Flanking suppression reports only the first touched button.
// - Host may disable noise immunity processing by configuration.
// - Shield and guard pins work only when configuration selects them.
// - Eight outputs, sensor n drives output n.
// - Special output pins act as sensor, shield, alert or buzzer.
// - Output pins present sensor status without I2C.
// - Power-up diagnostics record capacitor, range and short faults.
// - Reset pulse restores the whole block.
`timescale 1ns/10ps
module tfoc_top
   import tfoc_pkg::*;
(
   input  wire logic                    i_clk,
   input  wire logic                    i_ce,
   input  wire logic                    i_reset,
   input  wire logic [TFOC_NUM_OUT-1:0] i_sensor_on,
   input  wire logic [TFOC_NUM_OUT-1:0] i_sensor_is_prox,
   input  wire logic [TFOC_NUM_OUT-1:0] i_host_level,
   input  wire logic [2*TFOC_NUM_OUT-1:0] i_cfg_mode,
   input  wire logic [TFOC_PWM_W-1:0]   i_cfg_led_period,
   input  wire logic [TFOC_PWM_W-1:0]   i_cfg_led_duty,
   input  wire logic [TFOC_PWM_W-1:0]   i_cfg_buz_period,
   input  wire logic [TFOC_PWM_W-1:0]   i_cfg_buz_duty,
   input  wire logic [TFOC_BUZ_W-1:0]   i_cfg_buz_len,
   input  wire logic [1:0]              i_cfg_special_output_zero_func,
   input  wire logic [1:0]              i_cfg_special_output_one_func,
   input  wire logic                    i_cfg_guard_en,
   input  wire logic                    i_cfg_fss_en,
   input  wire logic                    i_cfg_noise_en,
   input  wire logic                    i_cfg_wake_en,
   input  wire logic                    i_cfg_update,
   input  wire logic                    i_cfg_crc_ok,
   input  wire logic                    i_cmd_sleep,
   input  wire logic                    i_cmd_resume,
   input  wire logic                    i_status_read,
   input  wire logic [TFOC_DIAG_W-1:0]  i_diag_fault,
   input  wire logic                    i_diag_done,
   output logic [TFOC_NUM_OUT-1:0]      o_led_drive_output,
   output logic                         o_special_output_zero,
   output logic                         o_special_output_zero_oe_n,
   output logic                         o_special_output_one,
   output logic                         o_special_output_one_oe_n,
   output logic                         o_driven_shield_pin,
   output logic                         o_guard_en,
   output logic                         o_noise_immunity_processing,
   output logic [TFOC_NUM_OUT-1:0]      o_status,
   output logic                         o_scan_strobe,
   output logic                         o_active,
   output logic [TFOC_DIAG_W-1:0]       o_diag_result,
   output logic                         o_diag_done,
   output logic                         o_cfg_reverted
);
   // Sensor and diagnostic levels come from the analog side, so synchronise
   wire logic [TFOC_NUM_OUT-1:0] sens_s;
   wire logic [TFOC_NUM_OUT-1:0] prox_s;
   wire logic [TFOC_DIAG_W:0]    diag_s;

   tfoc_sync #(.W(TFOC_NUM_OUT)) u_sync_sens (
      .i_clk   (i_clk),
      .i_ce    (i_ce),
      .i_reset (i_reset),
      .i_async (i_sensor_on),
      .o_sync  (sens_s)
   );

   tfoc_sync #(.W(TFOC_NUM_OUT)) u_sync_prox (
      .i_clk   (i_clk),
      .i_ce    (i_ce),
      .i_reset (i_reset),
      .i_async (i_sensor_is_prox),
      .o_sync  (prox_s)
   );

   tfoc_sync #(.W(TFOC_DIAG_W+1)) u_sync_diag (
      .i_clk   (i_clk),
      .i_ce    (i_ce),
      .i_reset (i_reset),
      .i_async ({i_diag_done, i_diag_fault}),
      .o_sync  (diag_s)
   );

   // Committed configuration: only a checked update replaces it, so a bad
   // image never reaches the outputs
   logic [2*TFOC_NUM_OUT-1:0] mode_q;
   logic [TFOC_PWM_W-1:0]     led_per_q;
   logic [TFOC_PWM_W-1:0]     led_duty_q;
   logic [TFOC_PWM_W-1:0]     buz_per_q;
   logic [TFOC_PWM_W-1:0]     buz_duty_q;
   logic [TFOC_BUZ_W-1:0]     buz_len_q;
   logic [1:0]                special_output_zero_q;
   logic [1:0]                special_output_one_q;
   logic                      guard_q;
   logic                      fss_q;
   logic                      noise_q;
   logic                      wake_q;
   logic                      reverted_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mode_q     <= '0;
         led_per_q  <= '1;
         led_duty_q <= '0;
         buz_per_q  <= '1;
         buz_duty_q <= '0;
         buz_len_q  <= '0;
         special_output_zero_q     <= TFOC_SPO_ALERT;
         special_output_one_q     <= TFOC_SPO_SENSOR;
         guard_q    <= 1'b0;
         fss_q      <= 1'b0;
         noise_q    <= 1'b1;
         wake_q     <= 1'b0;
         reverted_q <= 1'b0;
      end else if (i_ce && i_cfg_update) begin
         reverted_q <= !i_cfg_crc_ok;
         if (i_cfg_crc_ok) begin
            mode_q     <= i_cfg_mode;
            led_per_q  <= i_cfg_led_period;
            led_duty_q <= i_cfg_led_duty;
            buz_per_q  <= i_cfg_buz_period;
            buz_duty_q <= i_cfg_buz_duty;
            buz_len_q  <= i_cfg_buz_len;
            special_output_zero_q     <= i_cfg_special_output_zero_func;
            special_output_one_q     <= i_cfg_special_output_one_func;
            guard_q    <= i_cfg_guard_en;
            fss_q      <= i_cfg_fss_en;
            noise_q    <= i_cfg_noise_en;
            wake_q     <= i_cfg_wake_en;
         end
      end
   end

   // Operating state
   tfoc_state_type state_q;
   tfoc_state_type state_d;
   logic [TFOC_SCAN_W-1:0] scan_cnt_q;
   logic                   scan_q;
   logic [TFOC_DIAG_W-1:0] diag_q;
   logic                   diag_done_q;

   wire logic prox_event;
   wire logic scan_wrap = (scan_cnt_q == TFOC_SCAN_W'(TFOC_SCAN_CYC - 1));

   always_comb begin
      state_d = state_q;
      case (state_q)
         TFOC_ST_DIAG: begin
            if (diag_s[TFOC_DIAG_W]) begin
               state_d = TFOC_ST_ACTIVE;
            end
         end
         TFOC_ST_ACTIVE: begin
            if (i_cmd_sleep) begin
               state_d = TFOC_ST_SLEEP;
            end
         end
         TFOC_ST_SLEEP: begin
            if (i_cmd_resume || (wake_q && prox_event)) begin
               state_d = TFOC_ST_ACTIVE;
            end
         end
         default: state_d = TFOC_ST_DIAG;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_q     <= TFOC_ST_DIAG;
         scan_cnt_q  <= '0;
         scan_q      <= 1'b0;
         diag_q      <= '0;
         diag_done_q <= 1'b0;
      end else if (i_ce) begin
         state_q <= state_d;
         // Counter restarts on each return to Active, so the first scan after
         // a wake comes one full interval later
         if (state_q == TFOC_ST_ACTIVE) begin
            scan_cnt_q <= scan_wrap ? '0 : scan_cnt_q + 1'b1;
            scan_q     <= scan_wrap;
         end else begin
            scan_cnt_q <= '0;
            scan_q     <= 1'b0;
         end
         if (state_q == TFOC_ST_DIAG && diag_s[TFOC_DIAG_W]) begin
            diag_q      <= diag_s[TFOC_DIAG_W-1:0];
            diag_done_q <= 1'b1;
         end
      end
   end

   // Flanking suppression: while the reported button is held, newcomers stay hidden
   logic [TFOC_NUM_OUT-1:0] sens_prev_q;
   logic [TFOC_NUM_OUT-1:0] rep_q;
   wire logic [TFOC_NUM_OUT-1:0] rises = sens_s & ~sens_prev_q;
   wire logic [TFOC_NUM_OUT-1:0] first_rise = rises & (~rises + 1'b1);
   wire logic [TFOC_NUM_OUT-1:0] rep_d = !fss_q ? sens_s :
                                         ((rep_q & sens_s) != '0) ? (rep_q & sens_s) :
                                         first_rise;
   logic [TFOC_NUM_OUT-1:0] rep_prev_q;
   wire logic [TFOC_NUM_OUT-1:0] new_ev = rep_q & ~rep_prev_q;
   wire logic touch_event = (new_ev & ~prox_s) != '0;
   assign prox_event = (new_ev & prox_s) != '0;

   wire logic led_pwm;
   wire logic buz_pwm;

   tfoc_pwm #(.W(TFOC_PWM_W)) u_led_pwm (
      .i_clk    (i_clk),
      .i_ce     (i_ce),
      .i_reset  (i_reset),
      .i_period (led_per_q),
      .i_duty   (led_duty_q),
      .o_wave   (led_pwm)
   );

   tfoc_pwm #(.W(TFOC_PWM_W)) u_buz_pwm (
      .i_clk    (i_clk),
      .i_ce     (i_ce),
      .i_reset  (i_reset),
      .i_period (buz_per_q),
      .i_duty   (buz_duty_q),
      .o_wave   (buz_pwm)
   );

   logic [TFOC_NUM_OUT-1:0] tog_q;
   logic [TFOC_NUM_OUT-1:0] led_q;

   // One output per sensor, sensor n steers output n
   for (genvar n = 0; n < TFOC_NUM_OUT; n++) begin : g_out
      wire logic [1:0] md = mode_q[2*n +: 2];
      wire logic led_d = (md == TFOC_MODE_DIRECT) ? rep_q[n] :
                         (md == TFOC_MODE_TOGGLE) ? tog_q[n] :
                         (md == TFOC_MODE_HOST)   ? i_host_level[n] :
                         (rep_q[n] & led_pwm);
      always_ff @(posedge i_clk) begin
         if (i_reset) begin
            tog_q[n] <= 1'b0;
            led_q[n] <= 1'b0;
         end else if (i_ce) begin
            // Reported events only, so a suppressed neighbour never flips its LED
            if (new_ev[n]) begin
               tog_q[n] <= ~tog_q[n];
            end
            led_q[n] <= led_d;
         end
      end
   end

   // Buzzer burst and host alert
   logic [TFOC_BUZ_W-1:0] buz_cnt_q;
   logic                  alert_q;
   wire logic             buz_on = (buz_cnt_q != '0);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sens_prev_q <= '0;
         rep_q       <= '0;
         rep_prev_q  <= '0;
         buz_cnt_q   <= '0;
         alert_q     <= 1'b0;
      end else if (i_ce) begin
         sens_prev_q <= sens_s;
         rep_q       <= rep_d;
         rep_prev_q  <= rep_q;
         // A new touch restarts the burst instead of stacking a second one
         if (touch_event) begin
            buz_cnt_q <= buz_len_q;
         end else if (buz_on) begin
            buz_cnt_q <= buz_cnt_q - 1'b1;
         end
         // A new touch event in the read cycle keeps the alert high
         if (touch_event) begin
            alert_q <= 1'b1;
         end else if (i_status_read) begin
            alert_q <= 1'b0;
         end
      end
   end

   // Special pins; shield waveform is the buzzer-free scan strobe level
   function automatic logic spo_val(input logic [1:0] f, input logic a, input logic b,
                                    input logic s);
      case (f)
         TFOC_SPO_SHIELD: spo_val = s;
         TFOC_SPO_ALERT:  spo_val = ~a; // Alert is active low, driven high while clear and low while raised
         TFOC_SPO_BUZZER: spo_val = b;
         default:         spo_val = 1'b0;
      endcase
   endfunction

   logic special_output_zero_pin_q;
   logic special_output_one_pin_q;
   logic special_output_zero_oe_n_q;
   logic special_output_one_oe_n_q;
   logic shield_q;
   wire logic buz_wave = buz_on & buz_pwm;
   wire logic shield_en = (special_output_zero_q == TFOC_SPO_SHIELD) || (special_output_one_q == TFOC_SPO_SHIELD);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         special_output_zero_pin_q  <= 1'b0;
         special_output_one_pin_q  <= 1'b0;
         special_output_zero_oe_n_q <= 1'b1;
         special_output_one_oe_n_q <= 1'b1;
         shield_q    <= 1'b0;
      end else if (i_ce) begin
         special_output_zero_pin_q  <= spo_val(special_output_zero_q, alert_q, buz_wave, scan_q);
         special_output_one_pin_q  <= spo_val(special_output_one_q, alert_q, buz_wave, scan_q);
         special_output_zero_oe_n_q <= (special_output_zero_q == TFOC_SPO_SENSOR);
         special_output_one_oe_n_q <= (special_output_one_q == TFOC_SPO_SENSOR);
         shield_q    <= shield_en & scan_q;
      end
   end

   assign o_led_drive_output          = led_q;
   assign o_special_output_zero       = special_output_zero_pin_q;
   assign o_special_output_zero_oe_n  = special_output_zero_oe_n_q;
   assign o_special_output_one        = special_output_one_pin_q;
   assign o_special_output_one_oe_n   = special_output_one_oe_n_q;
   assign o_driven_shield_pin         = shield_q;
   assign o_guard_en                  = guard_q;
   assign o_noise_immunity_processing = noise_q;
   assign o_status                    = rep_q;
   assign o_scan_strobe               = scan_q;
   assign o_active                    = state_q[1];
   assign o_diag_result               = diag_q;
   assign o_diag_done                 = diag_done_q;
   assign o_cfg_reverted              = reverted_q;
endmodule : tfoc_top

// ===== hw/tfoc_pkg.sv
package tfoc_pkg;
   localparam int         TFOC_NUM_OUT      = 8;
   localparam int         TFOC_CLK_HZ       = 40_000_000;
   // Scan refresh interval in microseconds and its cycle count
   localparam int         TFOC_SCAN_US      = 100;
   localparam int         TFOC_SCAN_CYC     = (TFOC_SCAN_US * (TFOC_CLK_HZ / 1_000_000));
   localparam int         TFOC_SCAN_W       = 16;
   localparam int         TFOC_PWM_W        = 8;
   localparam int         TFOC_BUZ_W        = 16;
   localparam int         TFOC_DIAG_W       = 3;
   localparam logic [1:0] TFOC_MODE_DIRECT  = 2'h0;
   localparam logic [1:0] TFOC_MODE_TOGGLE  = 2'h1;
   localparam logic [1:0] TFOC_MODE_HOST    = 2'h2;
   localparam logic [1:0] TFOC_MODE_PWM     = 2'h3;
   localparam logic [1:0] TFOC_SPO_SENSOR   = 2'h0;
   localparam logic [1:0] TFOC_SPO_SHIELD   = 2'h1;
   localparam logic [1:0] TFOC_SPO_ALERT    = 2'h2;
   localparam logic [1:0] TFOC_SPO_BUZZER   = 2'h3;
   localparam int         TFOC_DIAG_CMOD    = 0;
   localparam int         TFOC_DIAG_CP      = 1;
   localparam int         TFOC_DIAG_SHORT   = 2;
   typedef enum logic [2:0] {
      TFOC_ST_DIAG   = 3'b001,
      TFOC_ST_ACTIVE = 3'b010,
      TFOC_ST_SLEEP  = 3'b100
   } tfoc_state_type;
endpackage : tfoc_pkg

// ===== hw/tfoc_sync.sv
`timescale 1ns/10ps
module tfoc_sync
   import tfoc_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_ce,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (i_ce) begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule : tfoc_sync

// ===== hw/tfoc_pwm.sv
`timescale 1ns/10ps
module tfoc_pwm
   import tfoc_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_ce,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_period,
   input  wire logic [W-1:0] i_duty,
   output logic              o_wave
);
   logic [W-1:0] cnt_q;
   logic         wave_q;
   wire  logic   wrap = (cnt_q >= i_period);

   // Duty above period saturates high; duty zero keeps the output off
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cnt_q  <= '0;
         wave_q <= 1'b0;
      end else if (i_ce) begin
         cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
         wave_q <= (cnt_q < i_duty);
      end
   end

   assign o_wave = wave_q;
endmodule : tfoc_pwm

// ===== bench/tfoc_top_sva.sv
`timescale 1ns/10ps
module tfoc_top_sva
   import tfoc_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_reset,
   input wire logic [7:0]  i_sensor_is_prox,
   input wire logic [7:0]  i_host_level,
   input wire logic [15:0] i_cfg_mode,
   input wire logic        i_cfg_noise_en,
   input wire logic        i_cfg_update,
   input wire logic        i_cfg_crc_ok,
   input wire logic        i_cmd_sleep,
   input wire logic        i_status_read,
   input wire logic [7:0]  o_led_drive_output,
   input wire logic        o_special_output_zero,
   input wire logic [7:0]  o_status,
   input wire logic        o_scan_strobe,
   input wire logic        o_active,
   input wire logic        o_cfg_reverted,
   input wire logic        o_noise_immunity_processing
);
   logic [15:0] mode_q;
   logic        ok_q;
   logic [7:0]  prev_q;
   logic [15:0] gap_q;
   logic        run_q;
   wire  [7:0]  rise = o_status & ~prev_q;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   // Shadow of the committed modes; a refused update leaves it alone
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ok_q   <= 1'b0;
         mode_q <= 16'h0000;
      end else if (i_cfg_update && i_cfg_crc_ok) begin
         ok_q   <= 1'b1;
         mode_q <= i_cfg_mode;
      end
   end

   // Gap only trusted while Active held since the last strobe
   always_ff @(posedge i_clk) begin
      prev_q <= o_status;
      gap_q  <= o_scan_strobe ? 16'h0000 : gap_q + 16'h0001;
      run_q  <= !i_reset && o_active && (run_q || o_scan_strobe);
   end

   sequence s_touch;
      rise != 8'h00 && i_sensor_is_prox == 8'h00;
   endsequence
   sequence s_alert_low;
      ##2 !o_special_output_zero;
   endsequence

   a_direct_led: assert property (
      ok_q && mode_q[1:0] == TFOC_MODE_DIRECT |-> o_led_drive_output[0] == $past(o_status[0]))
      else $error("led 0 not following status");
   a_host_led: assert property (
      ok_q && mode_q[5:4] == TFOC_MODE_HOST |-> o_led_drive_output[2] == $past(i_host_level[2]))
      else $error("led 2 not following host level");
   a_alert_set: assert property (s_touch |-> s_alert_low)
      else $error("alert not raised after touch");
   a_alert_hold: assert property (
      !o_special_output_zero && !$past(i_status_read) && !$past(i_reset) |=> !o_special_output_zero)
      else $error("alert dropped without status read");
   a_alert_release: assert property (
      i_status_read && rise == 8'h00 |-> ##2 o_special_output_zero)
      else $error("alert kept after status read");
   a_scan_period: assert property (o_scan_strobe && run_q |-> gap_q == TFOC_SCAN_CYC - 1)
      else $error("scan interval wrong");
   a_sleep_quiet: assert property ((!o_active) [*3] |-> !o_scan_strobe)
      else $error("scan while not active");
   a_sleep_enter: assert property (i_cmd_sleep && o_active |-> ##[1:2] !o_active)
      else $error("sleep command ignored");
   a_revert_flag: assert property (
      i_cfg_update |=> o_cfg_reverted == !$past(i_cfg_crc_ok))
      else $error("revert flag wrong");
   a_noise_commit: assert property (
      i_cfg_update && i_cfg_crc_ok |=> o_noise_immunity_processing == $past(i_cfg_noise_en))
      else $error("noise enable not committed");
endmodule : tfoc_top_sva

bind tfoc_top tfoc_top_sva chk_u (.*);

// ===== bench/tfoc_host_model.sv
`timescale 1ns/10ps
module tfoc_host_model
   import tfoc_pkg::*;
#(
   parameter int DELAY = 12
) (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_alert_n,
   output logic      o_status_read
);
   int wait_q;

   // Slow on purpose, so the alert has to hold until the read
   always_ff @(posedge i_clk) begin
      if (i_reset || i_alert_n) begin
         wait_q        <= 0;
         o_status_read <= 1'b0;
      end else begin
         wait_q        <= wait_q + 1;
         o_status_read <= (wait_q == DELAY);
      end
   end
endmodule : tfoc_host_model

// ===== bench/tfoc_bench.sv
`timescale 1ns/10ps
module tfoc_bench
   import tfoc_pkg::*;
;
   logic        i_clk = 1'b0;
   logic        i_ce = 1'b1;
   logic        i_reset = 1'b1;
   logic [7:0]  i_sensor_on = 8'h00;
   logic [7:0]  i_sensor_is_prox = 8'h00;
   logic [7:0]  i_host_level = 8'h00;
   logic [15:0] i_cfg_mode = 16'h0000;
   logic [7:0]  i_cfg_led_period = 8'h03;
   logic [7:0]  i_cfg_led_duty = 8'h01;
   logic [7:0]  i_cfg_buz_period = 8'h03;
   logic [7:0]  i_cfg_buz_duty = 8'h02;
   logic [15:0] i_cfg_buz_len = 16'h0014;
   logic [1:0]  i_cfg_special_output_zero_func = TFOC_SPO_ALERT;
   logic [1:0]  i_cfg_special_output_one_func = TFOC_SPO_SENSOR;
   logic        i_cfg_guard_en = 1'b0;
   logic        i_cfg_fss_en = 1'b0;
   logic        i_cfg_noise_en = 1'b1;
   logic        i_cfg_wake_en = 1'b0;
   logic        i_cfg_update = 1'b0;
   logic        i_cfg_crc_ok = 1'b0;
   logic        i_cmd_sleep = 1'b0;
   logic        i_cmd_resume = 1'b0;
   logic        i_status_read;
   logic [2:0]  i_diag_fault = 3'h0;
   logic        i_diag_done = 1'b0;
   logic [7:0]  o_led_drive_output;
   logic        o_special_output_zero;
   logic        o_special_output_zero_oe_n;
   logic        o_special_output_one;
   logic        o_special_output_one_oe_n;
   logic        o_driven_shield_pin;
   logic        o_guard_en;
   logic        o_noise_immunity_processing;
   logic [7:0]  o_status;
   logic        o_scan_strobe;
   logic        o_active;
   logic [2:0]  o_diag_result;
   logic        o_diag_done;
   logic        o_cfg_reverted;
   int          mismatches = 0;
   int          comparisons = 0;
   int          hits;
   wire  [10:0] mon = {o_scan_strobe, o_driven_shield_pin, o_special_output_one, o_led_drive_output};

   tfoc_top dut_u (.*);
   tfoc_host_model host_u (
      .i_clk         (i_clk),
      .i_reset       (i_reset),
      .i_alert_n     (o_special_output_zero),
      .o_status_read (i_status_read)
   );

   always #12.5 i_clk = ~i_clk;

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask : tick

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic count(input int n, input int sel);
      hits = 0;
      repeat (n) begin
         @(posedge i_clk);
         hits += int'(mon[sel]);
      end
   endtask : count

   task automatic cfg(input logic [15:0] mode, input logic [1:0] special_output_one, input logic flanking_suppression,
                      input logic guard, input logic noise, input logic crc);
      i_cfg_mode      <= mode;
      i_cfg_special_output_one_func <= special_output_one;
      i_cfg_fss_en    <= flanking_suppression;
      i_cfg_guard_en  <= guard;
      i_cfg_noise_en  <= noise;
      i_cfg_crc_ok    <= crc;
      i_cfg_update    <= 1'b1;
      tick(1);
      i_cfg_update    <= 1'b0;
      tick(3);
   endtask : cfg

   task automatic close_out();
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      tick(20);
      i_reset <= 1'b0;
      tick(2);
      chk("reset leds", o_led_drive_output, 16'h0000);
      chk("reset noise", o_noise_immunity_processing, 16'h0001);
      i_diag_fault <= 3'h5;
      i_diag_done  <= 1'b1;
      tick(6);
      chk("diag result", o_diag_result, 16'h0005);
      chk("diag done", o_diag_done, 16'h0001);
      chk("active", o_active, 16'h0001);
      // Out0 direct, out1 toggle, out2 host, out3 pwm, buzzer on pin one
      cfg(16'h00e4, TFOC_SPO_BUZZER, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("noise off", o_noise_immunity_processing, 16'h0000);
      i_sensor_on <= 8'h01;
      tick(6);
      chk("status", o_status, 16'h0001);
      chk("direct led", o_led_drive_output[0], 16'h0001);
      chk("alert", o_special_output_zero, 16'h0000);
      count(30, 8);
      chk("buzzer ran", 16'(hits != 0), 16'h0001);
      chk("buzzer ended", o_special_output_one, 16'h0000);
      chk("alert freed", o_special_output_zero, 16'h0001);
      i_sensor_on <= 8'h00;
      tick(6);
      chk("direct off", o_led_drive_output[0], 16'h0000);
      for (int k = 0; k < 2; k++) begin
         i_sensor_on <= 8'h02;
         tick(6);
         i_sensor_on <= 8'h00;
         tick(6);
         chk("toggle", o_led_drive_output[1], 16'(k == 0));
      end
      i_host_level <= 8'h04;
      tick(3);
      chk("host on", o_led_drive_output[2], 16'h0001);
      i_host_level <= 8'h00;
      tick(3);
      chk("host off", o_led_drive_output[2], 16'h0000);
      i_sensor_on <= 8'h08;
      tick(6);
      count(40, 3);
      chk("pwm duty", 16'(hits), 16'h000a);
      i_sensor_on <= 8'h00;
      // A refused update must not move pin zero off the alert
      i_cfg_special_output_zero_func <= TFOC_SPO_SENSOR;
      i_cfg_led_duty  <= 8'h02;
      i_cfg_buz_len   <= 16'h0030;
      cfg(16'h00e4, TFOC_SPO_BUZZER, 1'b0, 1'b0, 1'b1, 1'b0);
      chk("reverted", o_cfg_reverted, 16'h0001);
      chk("old noise", o_noise_immunity_processing, 16'h0000);
      chk("old special_output_zero", o_special_output_zero_oe_n, 16'h0000);
      i_cfg_special_output_zero_func <= TFOC_SPO_ALERT;
      cfg(16'h0000, TFOC_SPO_SHIELD, 1'b1, 1'b1, 1'b0, 1'b1);
      chk("guard", o_guard_en, 16'h0001);
      chk("shield oe", o_special_output_one_oe_n, 16'h0000);
      i_sensor_on <= 8'h30;
      tick(6);
      chk("flanking", o_status, 16'h0010);
      i_sensor_on <= 8'h00;
      count(8000, 9);
      chk("shield scans", 16'(hits), 16'h0002);
      i_cfg_wake_en <= 1'b1;
      cfg(16'h0000, TFOC_SPO_SENSOR, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("sensor oe", o_special_output_one_oe_n, 16'h0001);
      i_cmd_sleep <= 1'b1;
      tick(1);
      i_cmd_sleep <= 1'b0;
      count(8000, 10);
      chk("sleep scans", 16'(hits), 16'h0000);
      i_cmd_resume <= 1'b1;
      tick(1);
      i_cmd_resume <= 1'b0;
      tick(3);
      chk("resumed", o_active, 16'h0001);
      i_cmd_sleep      <= 1'b1;
      i_sensor_is_prox <= 8'h01;
      tick(1);
      i_cmd_sleep <= 1'b0;
      tick(6);
      chk("asleep", o_active, 16'h0000);
      i_sensor_on <= 8'h01;
      tick(6);
      chk("woken", o_active, 16'h0001);
      // Clock enable low must freeze the reported state
      i_ce        <= 1'b0;
      i_sensor_on <= 8'h00;
      tick(6);
      chk("frozen", o_status, 16'h0001);
      i_ce <= 1'b1;
      tick(6);
      chk("thawed", o_status, 16'h0000);
      i_sensor_is_prox <= 8'h00;
      i_reset          <= 1'b1;
      tick(2);
      i_reset <= 1'b0;
      tick(2);
      chk("rereset noise", o_noise_immunity_processing, 16'h0001);
      close_out();
   end

   // Whole run is near 16200 cycles
   initial begin
      tick(25000);
      mismatches++;
      close_out();
   end
endmodule : tfoc_bench
